// ### gim_params.svh
// Constants of the bus interface-message decoder: command codes, address limits, widths.
// Assumes inclusion by the package and the decoder; definitions only.
`ifndef GIM_PARAMS_SVH
`define GIM_PARAMS_SVH

// ----------------------------------------------------------------
// Addressing
// ----------------------------------------------------------------
`define GIM_ADDR_W 5
`define GIM_ADDR_DEFAULT 5'h14
`define GIM_ADDR_MAX 5'h1E
`define GIM_LISTEN_BASE 7'h20
`define GIM_TALK_BASE 7'h40
`define GIM_UNLISTEN 7'h3F
`define GIM_UNTALK 7'h5F

// ----------------------------------------------------------------
// Command groups (upper three bits of the 7-bit code)
// ----------------------------------------------------------------
`define GIM_GRP_ADDRESSED 3'h0
`define GIM_GRP_UNIVERSAL 3'h1

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define GIM_CMD_GTL 7'h01
`define GIM_CMD_GTR 7'h02
`define GIM_CMD_SDC 7'h04
`define GIM_CMD_PPC 7'h05
`define GIM_CMD_GET 7'h08
`define GIM_CMD_LLO 7'h11
`define GIM_CMD_DCL 7'h14
`define GIM_CMD_PPU 7'h15
`define GIM_CMD_SPE 7'h18
`define GIM_CMD_SPD 7'h19

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define GIM_SYNC_W 13

`endif

// ### gim_pkg.sv
// Types shared by the decoder modules.
// Assumes gim_params.svh is on the include path.
`default_nettype none
`include "gim_params.svh"

package gim_pkg;

  // Interface state presented to the instrument firmware
  typedef struct packed {
    logic remote;
    logic lockout;
    logic listener;
    logic talker;
    logic spoll;
    logic ppoll;
  } gim_state_t;

  // Synchronised bus pins
  typedef struct packed {
    logic [7:0] dio;
    logic atn_n;
    logic ifc_n;
    logic dav_n;
    logic local_req;
    logic ext_trig;
  } gim_pins_t;

  // Acceptor handshake states, one-hot
  typedef enum logic [1:0] {
    GIM_ACC_READY = 2'b01,
    GIM_ACC_HOLD = 2'b10
  } gim_acc_t;

endpackage : gim_pkg
`default_nettype wire

// ### gim_sync.sv
// Two-stage synchroniser for the asynchronous bus pins.
// Assumes one clock; first stage feeds only the second.
`default_nettype none

module gim_sync #(
  parameter int W = 8
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [W-1:0] D,
  input wire logic [W-1:0] INIT,
  output logic [W-1:0] Q
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // ----------------------------------------------------------------
  // Next values: reset loads idle pin levels so nothing fires on release
  // ----------------------------------------------------------------
  always_comb begin
    next_meta = RST ? INIT : D;
    next_q = RST ? INIT : meta;
  end

  // Registers only
  always_ff @(posedge CLOCK) begin
    meta <= next_meta;
    Q <= next_q;
  end

endmodule : gim_sync
`default_nettype wire

// ### gim_decoder.sv
// Device-side decoder of bus interface messages: acceptor handshake, addressing,
// universal and addressed commands, serial-poll status output.
// Assumes bus pins are asynchronous and open-collector; data lines given as true (non-inverted) levels.
`default_nettype none
`include "gim_params.svh"

module gim_decoder
  import gim_pkg::*;
#(
  parameter logic [4:0] DEFAULT_ADDR = `GIM_ADDR_DEFAULT
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [7:0] DIO_IN,
  output logic [7:0] DIO_OUT,
  output logic [7:0] DIO_OE,
  input wire logic ATN_N,
  input wire logic IFC_N,
  input wire logic DAV_N,
  output logic NRFD_OUT,
  output logic NRFD_OE,
  output logic NDAC_OUT,
  output logic NDAC_OE,
  input wire logic [4:0] ADDR,
  input wire logic LOCAL_REQ,
  input wire logic EXT_TRIG,
  input wire logic [7:0] STATUS_BYTE,
  output gim_state_t STATE,
  output logic CMD_CLEAR,
  output logic TRIGGER
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic in_group(input logic [6:0] code, input logic [2:0] grp);
    in_group = (code[6:4] == grp);
  endfunction : in_group

  gim_pins_t pins;
  gim_state_t st;
  gim_state_t next_st;
  gim_acc_t acc;
  gim_acc_t next_acc;
  logic [4:0] my_addr;
  logic acc_en;
  logic take;
  logic [6:0] code;
  logic is_cmd;
  logic universal;
  logic addressed;
  logic trig_prev;
  logic next_trig_prev;
  logic next_clear;
  logic next_trigger;
  logic [7:0] next_dio_out;
  logic [7:0] next_dio_oe;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  gim_sync #(.W(`GIM_SYNC_W)) u_sync (
    .CLOCK(CLOCK),
    .RST(RST),
    .D({DIO_IN, ATN_N, IFC_N, DAV_N, LOCAL_REQ, EXT_TRIG}),
    .INIT(13'h01C),
    .Q(pins)
  );

  // Out-of-range settings fall back to the default rather than aliasing a broadcast code
  assign my_addr = (ADDR > `GIM_ADDR_MAX) ? DEFAULT_ADDR : ADDR;

  // ----------------------------------------------------------------
  // Acceptor handshake: join in while attention is low or while listening
  // ----------------------------------------------------------------
  assign acc_en = ~pins.atn_n | st.listener;
  assign take = acc_en & (acc == GIM_ACC_READY) & ~pins.dav_n;
  assign NRFD_OUT = 1'b0;
  assign NDAC_OUT = 1'b0;
  assign NRFD_OE = acc_en & (acc == GIM_ACC_HOLD);
  assign NDAC_OE = acc_en & (acc == GIM_ACC_READY);

  always_comb begin
    case (acc)
      GIM_ACC_READY: next_acc = take ? GIM_ACC_HOLD : GIM_ACC_READY;
      GIM_ACC_HOLD: next_acc = (pins.dav_n | ~acc_en) ? GIM_ACC_READY : GIM_ACC_HOLD;
      default: next_acc = GIM_ACC_READY;
    endcase
    if (RST | ~pins.ifc_n) begin
      next_acc = GIM_ACC_READY;
    end
  end

  always_ff @(posedge CLOCK) begin
    acc <= next_acc;
  end

  // ----------------------------------------------------------------
  // Command classification; parity bit 7 ignored
  // ----------------------------------------------------------------
  assign code = pins.dio[6:0];
  assign is_cmd = take & ~pins.atn_n;
  assign universal = is_cmd & in_group(code, `GIM_GRP_UNIVERSAL);
  assign addressed = is_cmd & in_group(code, `GIM_GRP_ADDRESSED) & st.listener;

  // ----------------------------------------------------------------
  // Interface state and command effects
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_clear = 1'b0;
    next_trigger = 1'b0;
    next_trig_prev = pins.ext_trig;
    // Local key only works while not locked out; applied first so a remote command in the same cycle wins
    if (pins.local_req & ~st.lockout) begin
      next_st.remote = 1'b0;
    end
    // Addressing
    if (is_cmd) begin
      if (code == (`GIM_LISTEN_BASE | {2'b00, my_addr})) begin
        next_st.listener = 1'b1;
      end else if (code == `GIM_UNLISTEN) begin
        next_st.listener = 1'b0;
      end
      if (code == (`GIM_TALK_BASE | {2'b00, my_addr})) begin
        next_st.talker = 1'b1;
      end else if (code == `GIM_UNTALK || code[6:5] == 2'b10) begin
        next_st.talker = 1'b0;
      end
    end
    if (universal) begin
      case (code)
        `GIM_CMD_DCL: next_clear = 1'b1;
        `GIM_CMD_LLO: next_st.lockout = 1'b1;
        `GIM_CMD_SPE: next_st.spoll = 1'b1;
        `GIM_CMD_SPD: next_st.spoll = 1'b0;
        `GIM_CMD_PPU: next_st.ppoll = 1'b0;
        default: next_clear = 1'b0;
      endcase
    end
    if (addressed) begin
      case (code)
        `GIM_CMD_SDC: next_clear = 1'b1;
        `GIM_CMD_PPC: next_st.ppoll = 1'b1;
        `GIM_CMD_GET: next_trigger = 1'b1;
        `GIM_CMD_GTL: begin
          next_st.remote = 1'b0;
          next_st.lockout = 1'b0;
        end
        `GIM_CMD_GTR: next_st.remote = 1'b1;
        default: next_clear = 1'b0;
      endcase
    end
    // External trigger input rising edge shares the trigger output
    if (pins.ext_trig & ~trig_prev) begin
      next_trigger = 1'b1;
    end
    if (RST | ~pins.ifc_n) begin
      next_st = '0;
      next_clear = 1'b0;
      next_trigger = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    st <= next_st;
    CMD_CLEAR <= next_clear;
    TRIGGER <= next_trigger;
    trig_prev <= next_trig_prev;
  end

  assign STATE = st;

  // ----------------------------------------------------------------
  // Serial-poll status byte; only while attention is high, never a command
  // ----------------------------------------------------------------
  always_comb begin
    next_dio_out = STATUS_BYTE;
    next_dio_oe = {8{st.spoll & st.talker & pins.atn_n}};
    if (RST | ~pins.ifc_n) begin
      next_dio_out = 8'h00;
      next_dio_oe = 8'h00;
    end
  end

  always_ff @(posedge CLOCK) begin
    DIO_OUT <= next_dio_out;
    DIO_OE <= next_dio_oe;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_cmd_needs_atn: assert property (@(posedge CLOCK) disable iff (RST)
    (CMD_CLEAR | st.spoll & ~$past(st.spoll)) |-> $past(~pins.atn_n))
    else $error("command effect without attention low");

  a_dcl_clears: assert property (@(posedge CLOCK) disable iff (RST)
    (take & ~pins.atn_n & pins.ifc_n & code == `GIM_CMD_DCL) |=> CMD_CLEAR)
    else $error("device clear not signalled");

  a_sdc_listener: assert property (@(posedge CLOCK) disable iff (RST)
    (take & ~pins.atn_n & pins.ifc_n & code == `GIM_CMD_SDC) |=> (CMD_CLEAR == $past(st.listener)))
    else $error("selected clear addressing wrong");

  a_ifc_default: assert property (@(posedge CLOCK) disable iff (RST)
    ~pins.ifc_n |=> (st == '0 && DIO_OE == 8'h00 && !CMD_CLEAR))
    else $error("interface clear left state set");

  a_lockout_holds: assert property (@(posedge CLOCK) disable iff (RST)
    (st.lockout & st.remote & pins.ifc_n & ~addressed) |=> st.remote)
    else $error("remote left under lockout");

  a_spoll_set: assert property (@(posedge CLOCK) disable iff (RST)
    (universal & pins.ifc_n & code == `GIM_CMD_SPE) |=> st.spoll ##0 $stable(st.ppoll))
    else $error("serial poll not entered");

  a_get_addressed: assert property (@(posedge CLOCK) disable iff (RST)
    (take & ~pins.atn_n & pins.ifc_n & code == `GIM_CMD_GET & ~st.listener
     & ~(pins.ext_trig & ~trig_prev)) |=> !TRIGGER)
    else $error("trigger without listen address");

  a_stb_drive: assert property (@(posedge CLOCK) disable iff (RST)
    (st.spoll & st.talker & pins.atn_n & pins.ifc_n) |=> (DIO_OE == 8'hFF && DIO_OUT == $past(STATUS_BYTE)))
    else $error("status byte not driven");

  a_listen_addr: assert property (@(posedge CLOCK) disable iff (RST)
    (is_cmd & pins.ifc_n & code == (`GIM_LISTEN_BASE | {2'b00, my_addr})) |=> st.listener)
    else $error("own listen address ignored");

endmodule : gim_decoder
`default_nettype wire

// ### gim_ctrl_model.sv
// Behavioural bus controller that sends single interface bytes over the three-wire handshake.
// Assumes the decoder's open-drain enables are fed straight in; it moves lines on falling edges.
`default_nettype none

module gim_ctrl_model
  import gim_pkg::*;
(
  input wire logic CLOCK,
  input wire logic NRFD_OE,
  input wire logic NDAC_OE,
  output logic [7:0] DIO,
  output logic ATN_N,
  output logic DAV_N,
  output logic TIMED_OUT
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Source handshake
  // ----------------------------------------------------------------
  // Idle bus: attention off, no data valid
  initial begin
    DIO = 8'h00;
    ATN_N = 1'b1;
    DAV_N = 1'b1;
    TIMED_OUT = 1'b0;
  end

  // Bounded wait on one enable; a hang raises the flag instead of stalling the run
  task automatic wait_for(input logic nrfd, input logic lvl);
    int n;
    n = 0;
    while (((nrfd ? NRFD_OE : NDAC_OE) !== lvl) && n < 40) begin
      @(negedge CLOCK);
      n++;
    end
    if ((nrfd ? NRFD_OE : NDAC_OE) !== lvl) TIMED_OUT = 1'b1;
  endtask : wait_for

  // Only this model drives attention and interface bytes
  task automatic send(input logic [7:0] b, input logic atn_n);
    @(negedge CLOCK);
    ATN_N = atn_n;
    DIO = b;
    repeat (3) @(negedge CLOCK);
    wait_for(1'b1, 1'b0);
    DAV_N = 1'b0;
    repeat (4) @(negedge CLOCK);
    wait_for(1'b0, 1'b0);
    DAV_N = 1'b1;
    // Released lines float back to the idle level of the pull-ups
    DIO = 8'h00;
    repeat (4) @(negedge CLOCK);
  endtask : send

  // Hand the bus to a talker for a serial poll
  task automatic atn_off;
    @(negedge CLOCK);
    ATN_N = 1'b1;
  endtask : atn_off

endmodule : gim_ctrl_model
`default_nettype wire

// ### gpib_interface_message_decoder_bench.sv
// Self-checking bench of the interface-message decoder with a behavioural controller.
// Assumes gim_pkg, gim_decoder and gim_ctrl_model are compiled first.
`default_nettype none

module gpib_interface_message_decoder_bench
  import gim_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Wiring
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] b;
    logic [5:0] s;
    logic [7:0] c;
    logic [7:0] t;
  } gim_row_t;

  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic IFC_N = 1'b1;
  logic [4:0] ADDR = 5'h14;
  logic EXT_TRIG = 1'b0;
  logic LOCAL_REQ = 1'b0;
  logic [7:0] STATUS_BYTE = 8'h5A;
  logic [7:0] DIO_IN, DIO_OUT, DIO_OE;
  logic ATN_N, DAV_N, NRFD_OE, NDAC_OE, CMD_CLEAR, TRIGGER, to;
  gim_state_t STATE;
  logic [7:0] clr_cnt = 8'd0;
  logic [7:0] trg_cnt = 8'd0;
  int errors = 0;
  int checks_done = 0;

  // Rows: byte sent with attention low, then state, clear count, trigger count
  gim_row_t rows [17] = '{
    '{8'h34, 6'h08, 8'd0, 8'd0}, '{8'h02, 6'h28, 8'd0, 8'd0}, '{8'h11, 6'h38, 8'd0, 8'd0},
    '{8'h01, 6'h08, 8'd0, 8'd0}, '{8'h05, 6'h09, 8'd0, 8'd0}, '{8'h15, 6'h08, 8'd0, 8'd0},
    '{8'h08, 6'h08, 8'd0, 8'd1}, '{8'h04, 6'h08, 8'd1, 8'd1}, '{8'h14, 6'h08, 8'd2, 8'd1},
    '{8'h3F, 6'h00, 8'd2, 8'd1}, '{8'h04, 6'h00, 8'd2, 8'd1}, '{8'h08, 6'h00, 8'd2, 8'd1},
    '{8'h02, 6'h00, 8'd2, 8'd1}, '{8'h14, 6'h00, 8'd3, 8'd1}, '{8'h11, 6'h10, 8'd3, 8'd1},
    '{8'h18, 6'h12, 8'd3, 8'd1}, '{8'h54, 6'h16, 8'd3, 8'd1}};

  always #5 CLOCK = ~CLOCK;

  gim_decoder uut (.CLOCK(CLOCK), .RST(RST), .DIO_IN(DIO_IN), .DIO_OUT(DIO_OUT), .DIO_OE(DIO_OE),
    .ATN_N(ATN_N), .IFC_N(IFC_N), .DAV_N(DAV_N), .NRFD_OUT(), .NRFD_OE(NRFD_OE), .NDAC_OUT(),
    .NDAC_OE(NDAC_OE), .ADDR(ADDR), .LOCAL_REQ(LOCAL_REQ), .EXT_TRIG(EXT_TRIG),
    .STATUS_BYTE(STATUS_BYTE), .STATE(STATE), .CMD_CLEAR(CMD_CLEAR), .TRIGGER(TRIGGER));

  gim_ctrl_model ctrl (.CLOCK(CLOCK), .NRFD_OE(NRFD_OE), .NDAC_OE(NDAC_OE), .DIO(DIO_IN),
    .ATN_N(ATN_N), .DAV_N(DAV_N), .TIMED_OUT(to));

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  // Pulses last one cycle, so count them rather than sample them late
  always @(posedge CLOCK) begin
    if (CMD_CLEAR === 1'b1) clr_cnt <= clr_cnt + 8'd1;
    if (TRIGGER === 1'b1) trg_cnt <= trg_cnt + 8'd1;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  // Front-panel local key pressed long enough to pass the synchroniser
  task automatic local_key;
    LOCAL_REQ = 1'b1;
    repeat (4) @(negedge CLOCK);
    LOCAL_REQ = 1'b0;
    repeat (3) @(negedge CLOCK);
  endtask : local_key

  // A stuck handshake counts as a mismatch and ends the run
  always @(posedge to) begin
    errors++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(negedge CLOCK);
    chk({2'b00, STATE}, 8'h00);
    chk(DIO_OE, 8'h00);
    RST = 1'b0;
    foreach (rows[i]) begin
      ctrl.send(rows[i].b, 1'b0);
      chk({2'b00, STATE}, {2'b00, rows[i].s});
      chk(clr_cnt, rows[i].c);
      chk(trg_cnt, rows[i].t);
    end
    // Serial poll read-out once attention goes high
    ctrl.atn_off();
    repeat (4) @(negedge CLOCK);
    chk(DIO_OE, 8'hFF);
    chk(DIO_OUT, 8'h5A);
    ctrl.send(8'h19, 1'b0);
    chk({2'b00, STATE}, 8'h14);
    // A clear code with attention high is not taken at all by a device addressed to talk but not to listen
    ctrl.send(8'h14, 1'b1);
    chk(clr_cnt, 8'd3);
    EXT_TRIG = 1'b1;
    repeat (3) @(negedge CLOCK);
    EXT_TRIG = 1'b0;
    repeat (3) @(negedge CLOCK);
    chk(trg_cnt, 8'd2);
    IFC_N = 1'b0;
    repeat (4) @(negedge CLOCK);
    IFC_N = 1'b1;
    repeat (3) @(negedge CLOCK);
    chk({2'b00, STATE}, 8'h00);
    // Out-of-range setting falls back to the default address, then a new address
    ADDR = 5'h1F;
    ctrl.send(8'h34, 1'b0);
    chk({2'b00, STATE}, 8'h08);
    ctrl.send(8'h3F, 1'b0);
    ADDR = 5'h07;
    ctrl.send(8'h34, 1'b0);
    chk({2'b00, STATE}, 8'h00);
    ctrl.send(8'h27, 1'b0);
    chk({2'b00, STATE}, 8'h08);
    // Local key returns to manual control only while not locked out
    ctrl.send(8'h02, 1'b0);
    chk({2'b00, STATE}, 8'h28);
    local_key();
    chk({2'b00, STATE}, 8'h08);
    ctrl.send(8'h02, 1'b0);
    ctrl.send(8'h11, 1'b0);
    local_key();
    chk({2'b00, STATE}, 8'h38);
    // Own talk address, untalk, then another device's talk address
    ctrl.send(8'h47, 1'b0);
    chk({2'b00, STATE}, 8'h3C);
    ctrl.send(8'h5F, 1'b0);
    chk({2'b00, STATE}, 8'h38);
    ctrl.send(8'h47, 1'b0);
    ctrl.send(8'h41, 1'b0);
    chk({2'b00, STATE}, 8'h38);
    // A listener must treat command codes with attention high as plain data
    ctrl.send(8'h14, 1'b1);
    chk(clr_cnt, 8'd3);
    ctrl.send(8'h01, 1'b1);
    chk({2'b00, STATE}, 8'h38);
    // Reset in mid-run, then the first command after release
    RST = 1'b1;
    repeat (3) @(negedge CLOCK);
    chk({2'b00, STATE}, 8'h00);
    chk(DIO_OE, 8'h00);
    RST = 1'b0;
    ctrl.send(8'h27, 1'b0);
    chk({2'b00, STATE}, 8'h08);
    wrap_up();
  end

endmodule : gpib_interface_message_decoder_bench
`default_nettype wire
